// ---- core/shr_pkg.sv ----
// package for the shutter output routing block: widths and selector codes
// assumes every user of it is clocked by the timing generator pixel clock
package shr_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned SHR_GEN_NUM   = 4;
    localparam int unsigned SHR_FIELD_W   = 12;
    localparam int unsigned SHR_SEL_W     = 3;

    // ------------------------------------------------------------
    // pin selector codes
    // ------------------------------------------------------------
    typedef enum logic [SHR_SEL_W-1:0] {
        SHR_SEL_GEN0    = 3'h0,
        SHR_SEL_GEN1    = 3'h1,
        SHR_SEL_GEN2    = 3'h2,
        SHR_SEL_GEN3    = 3'h3,
        SHR_SEL_XOR_A   = 3'h4,
        SHR_SEL_XOR_B   = 3'h5,
        SHR_SEL_INVALID = 3'h6,
        SHR_SEL_PAIRED  = 3'h7
    } shr_sel_t;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [SHR_FIELD_W-1:0] SHR_FIELD_RST = 12'h000;
    localparam logic [SHR_FIELD_W-1:0] SHR_FIELD_ONE = 12'h001;
    localparam logic                   SHR_PIN_RST   = 1'h0;

endpackage : shr_pkg

// ---- core/shr_shutter_gen.sv ----
// one internal shutter generator: field-placed on/off, manual override,
// programmable active polarity
// assumes field_start and exposure_trigger are one-cycle pulses on clock
`timescale 1ns/1ps
module shr_shutter_gen
    import shr_pkg::*;
(
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    // framing
    input  wire logic                   field_start,
    input  wire logic                   exposure_trigger,
    // settings
    input  wire logic [SHR_FIELD_W-1:0] on_field_count,
    input  wire logic [SHR_FIELD_W-1:0] off_field_count,
    input  wire logic                   active_polarity,
    input  wire logic                   manual_enable,
    input  wire logic                   manual_on,
    // result
    output logic                        shutter_level,
    output logic                        shutter_is_on
);

    logic                   armed_q;
    logic [SHR_FIELD_W-1:0] field_cnt_q;
    logic                   on_q;

    // ------------------------------------------------------------
    // exposure field tracking
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            armed_q     <= 1'b0;
            field_cnt_q <= SHR_FIELD_RST;
        end
        else if (exposure_trigger)
        begin
            // field 0 is the first field after the trigger
            armed_q     <= 1'b1;
            field_cnt_q <= SHR_FIELD_RST;
        end
        else if (field_start && armed_q)
        begin
            field_cnt_q <= field_cnt_q + SHR_FIELD_ONE;
            if (field_cnt_q == off_field_count)
                armed_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // on/off state
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            on_q <= 1'b0;
        else if (manual_enable)
            on_q <= manual_on;
        else if (field_start && armed_q && !exposure_trigger)
        begin
            // off wins when both counts name the same field
            if (field_cnt_q == off_field_count)
                on_q <= 1'b0;
            else if (field_cnt_q == on_field_count)
                on_q <= 1'b1;
        end
    end

    assign shutter_is_on = on_q;
    assign shutter_level = active_polarity ? on_q : ~on_q;

endmodule : shr_shutter_gen

// ---- core/shr_top.sv ----
// shutter output routing: four shutter generators, three xor sources and
// three registered pin selectors for substrate bias, mech shutter, flash
// assumes all inputs come from timing generator logic on the same clock
`timescale 1ns/1ps
module shr_top
    import shr_pkg::*;
(
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    // framing from the timing generator
    input  wire logic                   vertical_field_sync,
    input  wire logic                   exposure_trigger,
    // per-generator settings, index n is shutter_gen_n
    input  wire logic [SHR_FIELD_W-1:0] on_field_count  [SHR_GEN_NUM],
    input  wire logic [SHR_FIELD_W-1:0] off_field_count [SHR_GEN_NUM],
    input  wire logic [SHR_GEN_NUM-1:0] active_polarity,
    input  wire logic [SHR_GEN_NUM-1:0] manual_enable,
    input  wire logic [SHR_GEN_NUM-1:0] manual_on,
    // substrate bias signals
    input  wire logic                   bias_signal_a,
    input  wire logic                   bias_signal_b,
    // routing settings
    input  wire logic [SHR_SEL_W-1:0]   substrate_bias_pin_select,
    input  wire logic [SHR_SEL_W-1:0]   mech_shutter_pin_select,
    input  wire logic [SHR_SEL_W-1:0]   flash_pin_select,
    input  wire logic                   bias_xor_a_select,
    input  wire logic                   bias_xor_b_select,
    input  wire logic                   paired_shutter_xor_select,
    // pins
    output logic                        substrate_bias_out,
    output logic                        mech_shutter_out,
    output logic                        flash_out,
    // state
    output logic [SHR_GEN_NUM-1:0]      shutter_on_state
);

    // framing
    logic                   vd_prev_q;
    logic                   field_start;
    // generator levels and the sources built from them
    logic [SHR_GEN_NUM-1:0] shut;
    logic                   xor_a;
    logic                   xor_b;
    logic                   xor_paired;
    // pin stage
    logic                   bias_pin_d;
    logic                   bias_pin_q;
    logic                   mech_pin_d;
    logic                   mech_pin_q;
    logic                   flash_pin_d;
    logic                   flash_pin_q;

    // ------------------------------------------------------------
    // field framing
    // ------------------------------------------------------------
    // a field begins on the falling edge of the vertical sync
    // the sync is a level from logic on this clock: no synchroniser
    // reset low so a sync held low through reset gives no false field
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            vd_prev_q <= 1'b0;
        else
            vd_prev_q <= vertical_field_sync;
    end

    assign field_start = vd_prev_q & ~vertical_field_sync;

    // ------------------------------------------------------------
    // shutter generators
    // ------------------------------------------------------------
    // index n of every setting bus belongs to shutter_gen_n
    // manual mode does not stop a generator's field counter
    for (genvar g = 0; g < SHR_GEN_NUM; g++)
    begin : g_gen
        shr_shutter_gen u_gen (
            .clock            (clock),
            .sys_rst          (sys_rst),
            .field_start      (field_start),
            .exposure_trigger (exposure_trigger),
            .on_field_count   (on_field_count[g]),
            .off_field_count  (off_field_count[g]),
            .active_polarity  (active_polarity[g]),
            .manual_enable    (manual_enable[g]),
            .manual_on        (manual_on[g]),
            .shutter_level    (shut[g]),
            .shutter_is_on    (shutter_on_state[g])
        );
    end

    // ------------------------------------------------------------
    // xor sources
    // ------------------------------------------------------------
    // all three mix generator levels, after polarity, not on-states
    // bias inputs come straight from outside logic on this clock
    always_comb
    begin
        if (bias_xor_a_select)
            xor_a = shut[0] ^ bias_signal_a;
        else
            xor_a = bias_signal_a;
    end

    always_comb
    begin
        if (bias_xor_b_select)
            xor_b = shut[0] ^ bias_signal_b;
        else
            xor_b = bias_signal_b;
    end

    always_comb
    begin
        if (paired_shutter_xor_select)
            xor_paired = shut[0] ^ shut[2];
        else
            xor_paired = shut[0] ^ shut[1];
    end

    // ------------------------------------------------------------
    // pin selectors
    // ------------------------------------------------------------
    // code 6 is never meant to be programmed; the pin simply holds its
    // last level so a stray write cannot glitch the shutter or flash
    // the three selectors share one encoding, so the cases match
    always_comb
    begin
        bias_pin_d = bias_pin_q;
        case (shr_sel_t'(substrate_bias_pin_select))
            SHR_SEL_GEN0:    bias_pin_d = shut[0];
            SHR_SEL_GEN1:    bias_pin_d = shut[1];
            SHR_SEL_GEN2:    bias_pin_d = shut[2];
            SHR_SEL_GEN3:    bias_pin_d = shut[3];
            SHR_SEL_XOR_A:   bias_pin_d = xor_a;
            SHR_SEL_XOR_B:   bias_pin_d = xor_b;
            SHR_SEL_INVALID: bias_pin_d = bias_pin_q;
            SHR_SEL_PAIRED:  bias_pin_d = xor_paired;
            default:         bias_pin_d = bias_pin_q;
        endcase
    end

    always_comb
    begin
        mech_pin_d = mech_pin_q;
        case (shr_sel_t'(mech_shutter_pin_select))
            SHR_SEL_GEN0:    mech_pin_d = shut[0];
            SHR_SEL_GEN1:    mech_pin_d = shut[1];
            SHR_SEL_GEN2:    mech_pin_d = shut[2];
            SHR_SEL_GEN3:    mech_pin_d = shut[3];
            SHR_SEL_XOR_A:   mech_pin_d = xor_a;
            SHR_SEL_XOR_B:   mech_pin_d = xor_b;
            SHR_SEL_INVALID: mech_pin_d = mech_pin_q;
            SHR_SEL_PAIRED:  mech_pin_d = xor_paired;
            default:         mech_pin_d = mech_pin_q;
        endcase
    end

    always_comb
    begin
        flash_pin_d = flash_pin_q;
        case (shr_sel_t'(flash_pin_select))
            SHR_SEL_GEN0:    flash_pin_d = shut[0];
            SHR_SEL_GEN1:    flash_pin_d = shut[1];
            SHR_SEL_GEN2:    flash_pin_d = shut[2];
            SHR_SEL_GEN3:    flash_pin_d = shut[3];
            SHR_SEL_XOR_A:   flash_pin_d = xor_a;
            SHR_SEL_XOR_B:   flash_pin_d = xor_b;
            SHR_SEL_INVALID: flash_pin_d = flash_pin_q;
            SHR_SEL_PAIRED:  flash_pin_d = xor_paired;
            default:         flash_pin_d = flash_pin_q;
        endcase
    end

    // registered so routed pins change cleanly, one clock after source
    // reset parks every pin low until the first routed level arrives
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            bias_pin_q <= SHR_PIN_RST;
        else
            bias_pin_q <= bias_pin_d;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            mech_pin_q <= SHR_PIN_RST;
        else
            mech_pin_q <= mech_pin_d;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            flash_pin_q <= SHR_PIN_RST;
        else
            flash_pin_q <= flash_pin_d;
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // one flop per pin, nothing combinational reaches the pads
    assign substrate_bias_out = bias_pin_q;
    assign mech_shutter_out   = mech_pin_q;
    assign flash_out          = flash_pin_q;

endmodule : shr_top

// ---- tb/shr_checker_assertions.sv ----
// checker for shr_top: pin routing, register stage, generator switching
// assumes it is bound to shr_top and sees only its ports, one clock domain
`timescale 1ns/1ps
module shr_checker
    import shr_pkg::*;
(
    // clock, reset, framing
    input wire logic                 clock, sys_rst, vertical_field_sync,
    // settings
    input wire logic [SHR_GEN_NUM-1:0] active_polarity, manual_enable,
    input wire logic [SHR_GEN_NUM-1:0] manual_on,
    input wire logic                 bias_signal_a, bias_signal_b,
    input wire logic [SHR_SEL_W-1:0] substrate_bias_pin_select,
    input wire logic [SHR_SEL_W-1:0] mech_shutter_pin_select,
    input wire logic [SHR_SEL_W-1:0] flash_pin_select,
    input wire logic                 bias_xor_a_select, bias_xor_b_select,
    input wire logic                 paired_shutter_xor_select,
    // pins and state
    input wire logic                 substrate_bias_out, mech_shutter_out,
    input wire logic                 flash_out,
    input wire logic [SHR_GEN_NUM-1:0] shutter_on_state
);
    // ----
    // properties
    // ----
    logic [3:0] lv;
    logic [7:0] src;
    logic       rst_q;
    // the edge after a reset release still shows reset values
    always_ff @(posedge clock) rst_q <= sys_rst;
    assign lv  = ~(active_polarity ^ shutter_on_state);
    assign src = {lv[0] ^ (paired_shutter_xor_select ? lv[2] : lv[1]), 1'h0,
                  lv[0] & bias_xor_b_select ^ bias_signal_b,
                  lv[0] & bias_xor_a_select ^ bias_signal_a, lv};
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst || rst_q);
    property p_bias; substrate_bias_pin_select != 3'h6 |=>
        substrate_bias_out == $past(src[substrate_bias_pin_select]);
    endproperty
    property p_mech; mech_shutter_pin_select != 3'h6 |=>
        mech_shutter_out == $past(src[mech_shutter_pin_select]); endproperty
    property p_flash; flash_pin_select != 3'h6 |=>
        flash_out == $past(src[flash_pin_select]); endproperty
    property p_paired; mech_shutter_pin_select == 3'h7 |=> mech_shutter_out
        == $past(lv[0] ^ (paired_shutter_xor_select ? lv[2] : lv[1]));
    endproperty
    property p_manual; 1'b1 |=> ((shutter_on_state ^ $past(manual_on))
        & $past(manual_enable)) == 4'h0; endproperty
    property p_hold; manual_enable == 4'h0 && !($past(vertical_field_sync)
        && !vertical_field_sync) |=> $stable(shutter_on_state); endproperty
    property p_pol; mech_shutter_pin_select == 3'h0 |=> mech_shutter_out
        == $past(active_polarity[0] ~^ shutter_on_state[0]); endproperty
    property p_reg; !$past(sys_rst) && $stable(flash_pin_select)
        && flash_pin_select != 3'h6 && $changed(src[flash_pin_select])
        |=> flash_out != $past(flash_out); endproperty
    a_bias: assert property (p_bias)
        else $error("bias pin routing wrong");
    a_mech: assert property (p_mech)
        else $error("mech pin routing wrong");
    a_flash: assert property (p_flash)
        else $error("flash pin routing wrong");
    a_paired: assert property (p_paired)
        else $error("paired xor source wrong");
    a_manual: assert property (p_manual)
        else $error("manual state not followed");
    a_hold: assert property (p_hold)
        else $error("state changed outside a field start");
    a_pol: assert property (p_pol)
        else $error("shutter level polarity wrong");
    a_reg: assert property (p_reg)
        else $error("pin not one clock behind its source");
    c_man: cover property (manual_enable[0] && manual_on[0]);
    c_auto: cover property ($rose(shutter_on_state[0]) && !manual_enable[0]);
    c_pair: cover property (mech_shutter_pin_select == 3'h7);
endmodule : shr_checker

// ---- tb/shr_partner.sv ----
// far side of the pins: source of the two substrate bias levels
// assumes the block's clock and reset; the pins are only received
`timescale 1ns/1ps
module shr_partner
(
    // clock, reset and pins
    input  wire logic clock, sys_rst,
    input  wire logic substrate_bias_out, mech_shutter_out, flash_out,
    // bias levels, changing so that a stuck xor input shows
    output logic      bias_signal_a = 1'b0,
    output logic      bias_signal_b = 1'b0
);
    logic [4:0] lf_q = 5'h01;
    always @(posedge clock) begin
        lf_q          <= {lf_q[3:0], lf_q[4] ^ lf_q[2]};
        bias_signal_a <= lf_q[0];
        bias_signal_b <= lf_q[3];
    end
endmodule : shr_partner

// ---- tb/shutter_output_routing_test.sv ----
// self-checking bench for shr_top: random settings, fields and triggers,
// then a manual phase after a second reset; a model predicts pins
`timescale 1ns/1ps
module shutter_output_routing_test
    import shr_pkg::*;
;
    // ----
    // stimulus, model and checks
    // ----
    logic clock = 0, sys_rst = 1, vertical_field_sync = 0;
    logic exposure_trigger = 0, ph = 0, m_vp = 0;
    logic [SHR_FIELD_W-1:0] on_field_count [SHR_GEN_NUM] = '{default: 0};
    logic [SHR_FIELD_W-1:0] off_field_count [SHR_GEN_NUM] = '{default: 0};
    logic [3:0] active_polarity = 0, manual_enable = 0, manual_on = 0;
    logic [3:0] shutter_on_state, m_on;
    logic [2:0] substrate_bias_pin_select = 0, mech_shutter_pin_select = 0;
    logic [2:0] flash_pin_select = 0, e_pin;
    logic bias_xor_a_select = 0, bias_xor_b_select = 0, flash_out;
    logic paired_shutter_xor_select = 0, bias_signal_a, bias_signal_b;
    logic substrate_bias_out, mech_shutter_out;
    logic [3:0] m_arm;
    logic [11:0] m_cnt;
    logic [31:0] rs = 32'h00010fd4, r, q;
    logic [7:0] s;
    int err_total = 0, checks = 0, cyc = 0;
    shr_top i_dut (.*);
    shr_partner i_far (.*);
    always #50 clock = ~clock;
    function automatic logic [31:0] xs();
        rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5;
        return rs;
    endfunction : xs
    function automatic logic [2:0] nz(logic [2:0] c);
        return (c == 3'h6) ? 3'h7 : c;
    endfunction : nz
    task results;
        if (err_total == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    task chk(string nm, logic [3:0] e, logic [3:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    always @(posedge clock) begin
        s = {m_on[0] ^ active_polarity[0] ^ (paired_shutter_xor_select
             ? m_on[2] ^ active_polarity[2] : m_on[1] ^ active_polarity[1]),
             1'h0, ~(m_on[0] ^ active_polarity[0]) & bias_xor_b_select
             ^ bias_signal_b, ~(m_on[0] ^ active_polarity[0])
             & bias_xor_a_select ^ bias_signal_a, ~(active_polarity ^ m_on)};
        e_pin <= sys_rst ? 3'h0 : {s[substrate_bias_pin_select],
                 s[mech_shutter_pin_select], s[flash_pin_select]};
        if (sys_rst) begin
            m_on = 0; m_arm = 0; m_cnt = 0;
        end else if (exposure_trigger) begin
            m_arm = 4'hf; m_cnt = 0;
        end else if (m_vp && !vertical_field_sync) begin
            // manual mode holds the level but the off field still disarms
            for (int n = 0; n < 4; n++)
                if (m_arm[n] && m_cnt == off_field_count[n]) begin
                    m_arm[n] = 1'b0;
                    if (!manual_enable[n]) m_on[n] = 1'b0;
                end else if (m_arm[n] && !manual_enable[n]
                             && m_cnt == on_field_count[n]) m_on[n] = 1'b1;
            m_cnt++;
        end
        if (!sys_rst) m_on = m_on & ~manual_enable | manual_on & manual_enable;
        m_vp = sys_rst ? 1'b0 : vertical_field_sync;
        r = xs();
        q = xs();
        if (r[2:0] == 3'h0) vertical_field_sync <= ~vertical_field_sync;
        exposure_trigger <= r[8:3] == 6'h0;
        manual_enable <= ph ? r[12:9] : 4'h0;
        manual_on <= r[16:13];
        on_field_count[q[1:0]] <= {10'h0, q[3:2]};
        off_field_count[q[5:4]] <= {10'h0, q[7:6]};
        if (r[19:17] == 3'h0) begin
            {active_polarity, bias_xor_a_select, bias_xor_b_select,
             paired_shutter_xor_select} <= q[31:25];
            substrate_bias_pin_select <= nz(q[24:22]);
            mech_shutter_pin_select <= nz(q[21:19]);
            flash_pin_select <= nz(q[18:16]);
        end
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            results();
        end
    end
    always @(negedge clock) if (cyc > 0) begin
        chk("bias pin", {3'h0, e_pin[2]}, {3'h0, substrate_bias_out});
        chk("mech pin", {3'h0, e_pin[1]}, {3'h0, mech_shutter_out});
        chk("flash pin", {3'h0, e_pin[0]}, {3'h0, flash_out});
        chk("on state", m_on, shutter_on_state);
    end
    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3000) @(posedge clock);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        ph <= 1'b1;
        repeat (2000) @(posedge clock);
        results();
    end
endmodule : shutter_output_routing_test
bind shr_top shr_checker i_chk (.*);
